// *** pkg/cfs_pkg.sv ***
// Constants for the flags, segment and address-forming block.
// Assumes an APB master with 32-bit data and one word per register.
package cfs_pkg;
    // Register byte offsets
    localparam logic [7:0] CFS_PSW_OFF    = 8'h00;
    localparam logic [7:0] CFS_OPA_OFF    = 8'h04;
    localparam logic [7:0] CFS_OPB_OFF    = 8'h08;
    localparam logic [7:0] CFS_ALUCTL_OFF = 8'h0c;
    localparam logic [7:0] CFS_RESULT_OFF = 8'h10;
    localparam logic [7:0] CFS_CSEG_OFF   = 8'h14;
    localparam logic [7:0] CFS_DSEG_OFF   = 8'h18;
    localparam logic [7:0] CFS_SSEG_OFF   = 8'h1c;
    localparam logic [7:0] CFS_ESEG_OFF   = 8'h20;
    localparam logic [7:0] CFS_IP_OFF     = 8'h24;
    localparam logic [7:0] CFS_SP_OFF     = 8'h28;
    localparam logic [7:0] CFS_SI_OFF     = 8'h2c;
    localparam logic [7:0] CFS_DI_OFF     = 8'h30;
    localparam logic [7:0] CFS_EOFF_OFF   = 8'h34;
    localparam logic [7:0] CFS_ADRCTL_OFF = 8'h38;
    localparam logic [7:0] CFS_PHYS_OFF   = 8'h3c;
    localparam logic [7:0] CFS_STEP_OFF   = 8'h40;

    // Status word bit positions
    localparam int CFS_CF_BIT = 0;
    localparam int CFS_PF_BIT = 2;
    localparam int CFS_AF_BIT = 4;
    localparam int CFS_ZF_BIT = 6;
    localparam int CFS_SF_BIT = 7;
    localparam int CFS_TF_BIT = 8;
    localparam int CFS_IF_BIT = 9;
    localparam int CFS_DF_BIT = 10;
    localparam int CFS_OF_BIT = 11;

    // Reset values and status word write mask
    localparam logic [15:0] CFS_PSW_RST    = 16'hf000;
    localparam logic [15:0] CFS_PSW_WMASK  = 16'h0fd5;
    localparam logic [15:0] CFS_CSEG_RST   = 16'hffff;
    localparam logic [15:0] CFS_ZERO16     = 16'h0000;

    // Control field positions
    localparam int CFS_ALU_BYTE_BIT = 3;
    localparam int CFS_ADR_OVEN_BIT = 4;
    localparam int CFS_ADR_OVSEG_LO = 5;
    localparam int CFS_STEP_WORD_BIT = 1;

    typedef enum logic [2:0] {
        CFS_OP_ADD = 3'b000, CFS_OP_ADC = 3'b001, CFS_OP_SUB = 3'b010,
        CFS_OP_SBB = 3'b011, CFS_OP_AND = 3'b100, CFS_OP_OR  = 3'b101,
        CFS_OP_XOR = 3'b110, CFS_OP_PASS = 3'b111
    } cfs_op_t;

    typedef enum logic [2:0] {
        CFS_REF_FETCH = 3'b000, CFS_REF_STACK = 3'b001, CFS_REF_VAR = 3'b010,
        CFS_REF_SSRC  = 3'b011, CFS_REF_SDST  = 3'b100, CFS_REF_BPB = 3'b101
    } cfs_ref_t;

    typedef enum logic [1:0] {
        CFS_SEG_C = 2'b00, CFS_SEG_D = 2'b01, CFS_SEG_S = 2'b10, CFS_SEG_E = 2'b11
    } cfs_seg_t;

    typedef enum logic [1:0] {
        CFS_INT_NONE = 2'b00, CFS_INT_SOFT = 2'b01,
        CFS_INT_NMI  = 2'b10, CFS_INT_MASK = 2'b11
    } cfs_int_t;
endpackage

// *** core/cfs_core.sv ***
// Flag logic, segment selection and physical address forming, APB slave.
// Assumes an APB master on core_clk; interrupt sources are synchronous.
`timescale 1ns/1ps
module cfs_core
    import cfs_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irqMaskable,
    input  wire logic        irqNmi,
    input  wire logic        swInt,
    input  wire logic        instrDone,
    output logic             intTake,
    output logic [1:0]       intCause,
    output logic             singleStepTrap,
    output logic [19:0]      physAddr
);
    logic [15:0] pswQ;
    logic [15:0] opAQ;
    logic [15:0] opBQ;
    logic [15:0] resultQ;
    logic [7:0]  aluCtlQ;
    logic [15:0] cSegQ;
    logic [15:0] dSegQ;
    logic [15:0] sSegQ;
    logic [15:0] eSegQ;
    logic [15:0] ipQ;
    logic [15:0] spQ;
    logic [15:0] siQ;
    logic [15:0] diQ;
    logic [15:0] effOffQ;
    logic [7:0]  adrCtlQ;
    logic [19:0] physQ;
    logic        ovRefusedQ;
    logic        aluStepQ;

    logic        wrEn;
    logic        rdSetup;
    logic        mapped;
    logic [31:0] rdMux;

    // Zero wait states; read data is captured in the setup cycle
    assign pready  = 1'b1;
    assign wrEn    = psel & penable & pwrite;
    assign rdSetup = psel & ~penable & ~pwrite;

    always_comb begin
        mapped = 1'b1;
        rdMux  = 32'h0000_0000;
        unique case (paddr)
            CFS_PSW_OFF:    rdMux = {16'h0000, pswQ};
            CFS_OPA_OFF:    rdMux = {16'h0000, opAQ};
            CFS_OPB_OFF:    rdMux = {16'h0000, opBQ};
            CFS_ALUCTL_OFF: rdMux = {24'h000000, aluCtlQ};
            CFS_RESULT_OFF: rdMux = {16'h0000, resultQ};
            CFS_CSEG_OFF:   rdMux = {16'h0000, cSegQ};
            CFS_DSEG_OFF:   rdMux = {16'h0000, dSegQ};
            CFS_SSEG_OFF:   rdMux = {16'h0000, sSegQ};
            CFS_ESEG_OFF:   rdMux = {16'h0000, eSegQ};
            CFS_IP_OFF:     rdMux = {16'h0000, ipQ};
            CFS_SP_OFF:     rdMux = {16'h0000, spQ};
            CFS_SI_OFF:     rdMux = {16'h0000, siQ};
            CFS_DI_OFF:     rdMux = {16'h0000, diQ};
            CFS_EOFF_OFF:   rdMux = {16'h0000, effOffQ};
            CFS_ADRCTL_OFF: rdMux = {23'h000000, ovRefusedQ, adrCtlQ};
            CFS_PHYS_OFF:   rdMux = {12'h000, physQ};
            CFS_STEP_OFF:   rdMux = 32'h0000_0000;
            default:        mapped = 1'b0;
        endcase
    end

    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rdSetup) begin
            prdata <= rdMux;
        end
    end

    // Arithmetic and flag evaluation
    cfs_op_t     op;
    logic        byteMode;
    logic        isSub;
    logic        isLogic;
    logic        cin;
    logic [16:0] sumW;
    logic [8:0]  sumB;
    logic [15:0] res;
    logic        topA;
    logic        topB;
    logic        topR;
    logic        fCarry;
    logic        fHalf;
    logic        fOver;
    logic        fSign;
    logic        fPar;
    logic        fZero;

    assign op       = cfs_op_t'(aluCtlQ[2:0]);
    assign byteMode = aluCtlQ[CFS_ALU_BYTE_BIT];
    assign isSub    = (op == CFS_OP_SUB) || (op == CFS_OP_SBB);
    assign isLogic  = op[2];
    assign cin      = ((op == CFS_OP_ADC) || (op == CFS_OP_SBB)) & pswQ[CFS_CF_BIT];

    always_comb begin
        sumW = 17'h00000;
        sumB = 9'h000;
        res  = 16'h0000;
        unique case (op)
            CFS_OP_ADD, CFS_OP_ADC: begin
                sumW = {1'b0, opAQ} + {1'b0, opBQ} + {16'h0000, cin};
                sumB = {1'b0, opAQ[7:0]} + {1'b0, opBQ[7:0]} + {8'h00, cin};
                res  = sumW[15:0];
            end
            CFS_OP_SUB, CFS_OP_SBB: begin
                sumW = {1'b0, opAQ} - {1'b0, opBQ} - {16'h0000, cin};
                sumB = {1'b0, opAQ[7:0]} - {1'b0, opBQ[7:0]} - {8'h00, cin};
                res  = sumW[15:0];
            end
            CFS_OP_AND:  res = opAQ & opBQ;
            CFS_OP_OR:   res = opAQ | opBQ;
            CFS_OP_XOR:  res = opAQ ^ opBQ;
            CFS_OP_PASS: res = opAQ;
        endcase
        if (byteMode) begin
            res = {8'h00, res[7:0]};
        end
    end

    assign topA   = byteMode ? opAQ[7] : opAQ[15];
    assign topB   = byteMode ? opBQ[7] : opBQ[15];
    assign topR   = byteMode ? res[7] : res[15];
    assign fHalf  = ~isLogic & (opAQ[4] ^ opBQ[4] ^ res[4]);
    assign fCarry = ~isLogic & (byteMode ? sumB[8] : sumW[16]);
    // Subtract overflows when operand signs differ, add when they match
    assign fOver  = ~isLogic & ((topA ^ topB) == isSub) & (topR != topA);
    assign fSign  = topR;
    assign fPar   = byteMode ? ~^res[7:0] : ~^res;
    assign fZero  = (res == 16'h0000);

    logic aluGo;
    assign aluGo = wrEn & (paddr == CFS_ALUCTL_OFF);

    // Control bits written by software; hardware owns bits 15:12
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pswQ <= CFS_PSW_RST;
        end else if (wrEn && paddr == CFS_PSW_OFF) begin
            pswQ <= (pwdata[15:0] & CFS_PSW_WMASK) | (CFS_PSW_RST & ~CFS_PSW_WMASK);
        end else if (aluStepQ) begin
            pswQ[CFS_AF_BIT] <= fHalf;
            pswQ[CFS_CF_BIT] <= fCarry;
            pswQ[CFS_OF_BIT] <= fOver;
            pswQ[CFS_SF_BIT] <= fSign;
            pswQ[CFS_PF_BIT] <= fPar;
            pswQ[CFS_ZF_BIT] <= fZero;
        end
    end

    // Operation runs the cycle after the control write, on the new control
    always_ff @(posedge core_clk) begin
        if (rst) begin
            aluStepQ <= 1'b0;
        end else begin
            aluStepQ <= aluGo;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            aluCtlQ <= 8'h00;
            opAQ    <= CFS_ZERO16;
            opBQ    <= CFS_ZERO16;
            resultQ <= CFS_ZERO16;
        end else begin
            if (aluGo) begin
                aluCtlQ <= pwdata[7:0];
            end
            if (wrEn && paddr == CFS_OPA_OFF) begin
                opAQ <= pwdata[15:0];
            end
            if (wrEn && paddr == CFS_OPB_OFF) begin
                opBQ <= pwdata[15:0];
            end
            if (aluStepQ) begin
                resultQ <= res;
            end
        end
    end

    // Segment bases and offsets, all unsigned 16-bit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cSegQ   <= CFS_CSEG_RST;
            dSegQ   <= CFS_ZERO16;
            sSegQ   <= CFS_ZERO16;
            eSegQ   <= CFS_ZERO16;
            ipQ     <= CFS_ZERO16;
            spQ     <= CFS_ZERO16;
            effOffQ <= CFS_ZERO16;
        end else if (wrEn) begin
            if (paddr == CFS_CSEG_OFF) cSegQ <= pwdata[15:0];
            if (paddr == CFS_DSEG_OFF) dSegQ <= pwdata[15:0];
            if (paddr == CFS_SSEG_OFF) sSegQ <= pwdata[15:0];
            if (paddr == CFS_ESEG_OFF) eSegQ <= pwdata[15:0];
            if (paddr == CFS_IP_OFF) ipQ <= pwdata[15:0];
            if (paddr == CFS_SP_OFF) spQ <= pwdata[15:0];
            if (paddr == CFS_EOFF_OFF) effOffQ <= pwdata[15:0];
        end
    end

    // Index registers: software load or automatic string step
    logic        stepGo;
    logic [15:0] stepAmt;
    assign stepGo  = wrEn & (paddr == CFS_STEP_OFF);
    assign stepAmt = pwdata[CFS_STEP_WORD_BIT] ? 16'h0002 : 16'h0001;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            siQ <= CFS_ZERO16;
            diQ <= CFS_ZERO16;
        end else if (stepGo && pswQ[CFS_DF_BIT]) begin
            siQ <= siQ - stepAmt;
            diQ <= diQ - stepAmt;
        end else if (stepGo) begin
            siQ <= siQ + stepAmt;
            diQ <= diQ + stepAmt;
        end else if (wrEn && paddr == CFS_SI_OFF) begin
            siQ <= pwdata[15:0];
        end else if (wrEn && paddr == CFS_DI_OFF) begin
            diQ <= pwdata[15:0];
        end
    end

    // Segment choice per reference kind
    cfs_ref_t    refKind;
    cfs_seg_t    ovSeg;
    logic        ovEn;
    cfs_seg_t    segSel;
    logic        ovAllowed;
    logic [15:0] offSel;
    logic [15:0] baseSel;
    logic [19:0] physNext;

    assign refKind = cfs_ref_t'(pwdata[2:0]);
    assign ovEn    = pwdata[CFS_ADR_OVEN_BIT];
    assign ovSeg   = cfs_seg_t'(pwdata[CFS_ADR_OVSEG_LO +: 2]);

    always_comb begin
        ovAllowed = 1'b0;
        segSel    = CFS_SEG_D;
        offSel    = effOffQ;
        unique case (refKind)
            CFS_REF_FETCH: begin
                segSel = CFS_SEG_C;
                offSel = ipQ;
            end
            CFS_REF_STACK: begin
                segSel = CFS_SEG_S;
                offSel = spQ;
            end
            CFS_REF_VAR: begin
                segSel    = CFS_SEG_D;
                ovAllowed = 1'b1;
            end
            CFS_REF_SSRC: begin
                segSel    = CFS_SEG_D;
                offSel    = siQ;
                ovAllowed = 1'b1;
            end
            CFS_REF_SDST: begin
                segSel = CFS_SEG_E;
                offSel = diQ;
            end
            CFS_REF_BPB: begin
                segSel    = CFS_SEG_S;
                ovAllowed = 1'b1;
            end
            default: begin
                segSel = CFS_SEG_D;
            end
        endcase
        // Where no alternate is allowed the prefix is ignored, not faulted
        if (ovEn && ovAllowed) begin
            segSel = ovSeg;
        end
    end

    always_comb begin
        unique case (segSel)
            CFS_SEG_C: baseSel = cSegQ;
            CFS_SEG_D: baseSel = dSegQ;
            CFS_SEG_S: baseSel = sSegQ;
            CFS_SEG_E: baseSel = eSegQ;
        endcase
    end

    // Carry out of bit 19 simply falls off
    assign physNext = {baseSel, 4'h0} + {4'h0, offSel};

    logic adrGo;
    assign adrGo = wrEn & (paddr == CFS_ADRCTL_OFF);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            adrCtlQ    <= 8'h00;
            physQ      <= 20'h00000;
            ovRefusedQ <= 1'b0;
        end else if (adrGo) begin
            adrCtlQ    <= pwdata[7:0];
            physQ      <= physNext;
            ovRefusedQ <= ovEn & ~ovAllowed;
        end
    end

    assign physAddr = physQ;

    // Interrupt acceptance, registered; intTake is high for every cycle a request is accepted
    cfs_int_t intNext;
    always_comb begin
        intNext = CFS_INT_NONE;
        if (swInt) begin
            intNext = CFS_INT_SOFT;
        end else if (irqNmi) begin
            intNext = CFS_INT_NMI;
        end else if (irqMaskable && pswQ[CFS_IF_BIT]) begin
            intNext = CFS_INT_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            intTake  <= 1'b0;
            intCause <= CFS_INT_NONE;
        end else begin
            intTake  <= (intNext != CFS_INT_NONE);
            intCause <= intNext;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            singleStepTrap <= 1'b0;
        end else begin
            singleStepTrap <= instrDone & pswQ[CFS_TF_BIT];
        end
    end
endmodule

// *** sim/cfs_props.sv ***
// Checker for the flag, segment and address block, bound to cfs_core.
// Sees only the core ports; reset is synchronous and active high.
`timescale 1ns/1ps
module cfs_props
    import cfs_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irqMaskable,
    input wire logic        irqNmi,
    input wire logic        swInt,
    input wire logic        instrDone,
    input wire logic        intTake,
    input wire logic [1:0]  intCause,
    input wire logic        singleStepTrap,
    input wire logic [19:0] physAddr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Mirror of the maskable enable; only status word writes move it
    logic maskEnQ;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            maskEnQ <= 1'b0;
        end else if (psel && penable && pwrite && paddr == CFS_PSW_OFF) begin
            maskEnQ <= pwdata[CFS_IF_BIT];
        end
    end

    sequence s_badSetup;
        psel && !penable && paddr > CFS_STEP_OFF;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_adrWr;
        psel && penable && pwrite && paddr == CFS_ADRCTL_OFF;
    endsequence

    a_soft_first: assert property (swInt |=> intTake && intCause == CFS_INT_SOFT)
        else $error("soft request not taken first");
    a_nmi_second: assert property (irqNmi && !swInt |=> intCause == CFS_INT_NMI)
        else $error("nonmaskable request not taken");
    a_mask_gate: assert property (intCause == CFS_INT_MASK
        |-> $past(irqMaskable && !irqNmi && !swInt))
        else $error("maskable cause without its request");
    a_no_request: assert property (!(irqMaskable || irqNmi || swInt)
        |=> !intTake && intCause == CFS_INT_NONE)
        else $error("interrupt taken with no request");
    a_take_cause: assert property (intTake == (intCause != CFS_INT_NONE))
        else $error("take and cause disagree");
    a_trap_cause: assert property (singleStepTrap |-> $past(instrDone))
        else $error("trap without completed instruction");
    a_phys_hold: assert property ($changed(physAddr)
        |-> $past(psel && penable && pwrite && paddr == CFS_ADRCTL_OFF))
        else $error("physical address moved without request");
    a_read_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved outside read setup");
    a_ready_high: assert property (pready)
        else $error("ready low");
    a_err_unmapped: assert property (s_badSetup ##1 s_access |-> pslverr)
        else $error("no error on unmapped access");
    a_mask_blocked: assert property (irqMaskable && !irqNmi && !swInt && !maskEnQ
        |=> !intTake)
        else $error("maskable request taken while disabled");
    a_mask_taken: assert property (irqMaskable && !irqNmi && !swInt && maskEnQ
        |=> intTake && intCause == CFS_INT_MASK)
        else $error("enabled maskable request not taken");
    c_adr_req: cover property (s_adrWr);
endmodule

bind cfs_core cfs_props i_props (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irqMaskable(irqMaskable), .irqNmi(irqNmi), .swInt(swInt), .instrDone(instrDone),
    .intTake(intTake), .intCause(intCause), .singleStepTrap(singleStepTrap),
    .physAddr(physAddr));

// *** sim/testbench.sv ***
// Self-checking bench for cfs_core: registers over APB, flags, addresses.
// Assumes the zero-wait APB slave and registered interrupt outputs.
`timescale 1ns/1ps
module testbench
    import cfs_pkg::*;
;
    logic        core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, e, c;
    logic        pready, pslverr, intTake, singleStepTrap, bm, ov, rf;
    logic        irqMaskable = 0, irqNmi = 0, swInt = 0, instrDone = 0;
    logic [1:0]  intCause;
    logic [19:0] physAddr;
    logic [32:0] mq, expQ [$];
    logic [3:0]  ev, evQ [$];
    logic [15:0] a, b, pv, st, si, di, pswM, sg [4], of [5];
    logic [2:0]  op;
    int          err_total = 0, num_checks = 0, cyc = 0, i, j, k, d;
    int          dS [6] = '{0, 2, 1, 1, 3, 2};
    int          oI [6] = '{0, 1, 4, 2, 3, 4};

    always #4 core_clk = ~core_clk;

    cfs_core i_dut (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irqMaskable(irqMaskable), .irqNmi(irqNmi), .swInt(swInt),
        .instrDone(instrDone), .intTake(intTake), .intCause(intCause),
        .singleStepTrap(singleStepTrap), .physAddr(physAddr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        if (err_total == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Cycle ceiling well above the roughly 1800 cycles the tests take
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    // Read data is taken only at the edge that completes the access
    always @(posedge core_clk) begin
        if (psel && penable && !pwrite && pready) begin
            mq = expQ.pop_front();
            check({31'h0, pslverr}, {31'h0, mq[32]});
            check(prdata, mq[31:0]);
            if (paddr == CFS_PHYS_OFF)
                check({12'h0, physAddr}, mq[31:0]);
        end
    end

    // Interrupt and trap notes, oldest first, taken when either output shows
    always @(posedge core_clk) begin
        if (!rst && (intTake || singleStepTrap)) begin
            check(32'(evQ.size() != 0), 32'h1);
            ev = 4'h0;
            if (evQ.size() != 0)
                ev = evQ.pop_front();
            check({31'h0, singleStepTrap}, {31'h0, ev[3]});
            check({31'h0, intTake}, {31'h0, ev[2]});
            check({30'h0, intCause}, {30'h0, ev[1:0]});
        end
    end

    task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
        @(posedge core_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= dt;
        @(posedge core_clk);
        penable <= 1;
        // Only the bench ceiling ends a wait for ready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
        xfer(1'b1, ad, dt);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input logic er = 1'b0);
        expQ.push_back({er, ex});
        xfer(1'b0, ad, 32'h0);
    endtask

    // Returns flag bits in the upper half and the result in the lower
    function automatic logic [31:0] alu(input logic [2:0] o, input logic bym,
                                        input logic [15:0] x, y, input logic ci);
        logic [16:0] s;
        logic [4:0]  h;
        logic [15:0] r, f;
        logic        sb, cy, vf;
        int          n;
        n = bym ? 8 : 16;
        if (bym) begin
            x[15:8] = 8'h00;
            y[15:8] = 8'h00;
        end
        ci = ci & o[0];
        sb = o[1];
        s = sb ? {1'b0, x} - y - ci : x + y + ci;
        h = sb ? {1'b0, x[3:0]} - y[3:0] - ci : x[3:0] + y[3:0] + ci;
        cy = s[n];
        vf = ((x[n-1] ^ y[n-1]) == sb) && (s[n-1] ^ x[n-1]);
        r = s[15:0];
        if (o[2]) begin
            r = (o == 3'b111) ? x : o[1] ? x ^ y : o[0] ? x | y : x & y;
            cy = 0;
            h = 0;
            vf = 0;
        end
        if (bym)
            r[15:8] = 8'h00;
        f = 16'h0000;
        f[CFS_CF_BIT] = cy;
        f[CFS_PF_BIT] = ~^r;
        f[CFS_AF_BIT] = h[4];
        f[CFS_ZF_BIT] = r == 16'h0000;
        f[CFS_SF_BIT] = r[n-1];
        f[CFS_OF_BIT] = vf;
        return {f, r};
    endfunction

    initial begin
        void'($urandom(27));
        repeat (3) @(posedge core_clk);
        rst <= 0;
        rd(CFS_PSW_OFF, 32'h0000f000);
        rd(CFS_CSEG_OFF, 32'h0000ffff);
        rd(CFS_DSEG_OFF, 32'h0);
        rd(8'h44, 32'h0, 1'b1);
        for (i = 0; i < 56; i++) begin
            op = 3'(i % 8);
            bm = (i < 14) ? 1'((i / 7) % 2) : 1'($urandom);
            a = (i < 14) ? 16'h7fff : 16'($urandom);
            b = (i < 14) ? 16'h0001 : 16'($urandom);
            pv = 16'($urandom);
            wr(CFS_PSW_OFF, 32'(pv));
            pswM = (pv & CFS_PSW_WMASK) | CFS_PSW_RST;
            wr(CFS_OPA_OFF, 32'(a));
            wr(CFS_OPB_OFF, 32'(b));
            wr(CFS_ALUCTL_OFF, {28'h0, bm, op});
            e = alu(op, bm, a, b, pswM[CFS_CF_BIT]);
            pswM = (pswM & ~16'h08d5) | e[31:16];
            rd(CFS_RESULT_OFF, {16'h0, e[15:0]});
            rd(CFS_PSW_OFF, 32'(pswM));
        end
        // A write to the result register must be ignored
        wr(CFS_RESULT_OFF, ~e);
        rd(CFS_RESULT_OFF, {16'h0, e[15:0]});
        for (i = 0; i < 2; i++) begin
            for (j = 0; j < 4; j++) begin
                sg[j] = i ? 16'($urandom) : 16'hffff;
                wr(8'(CFS_CSEG_OFF + 4 * j), 32'(sg[j]));
            end
            for (j = 0; j < 5; j++) begin
                of[j] = i ? 16'($urandom) : 16'hffff;
                wr(8'(CFS_IP_OFF + 4 * j), 32'(of[j]));
            end
            for (k = 0; k < 6; k++) begin
                for (j = 0; j < 5; j++) begin
                    ov = j < 4;
                    d = (ov && k inside {2, 3, 5}) ? j : dS[k];
                    rf = ov && !(k inside {2, 3, 5});
                    c = {25'h0, 2'(j), ov, 1'b0, 3'(k)};
                    wr(CFS_ADRCTL_OFF, c);
                    rd(CFS_PHYS_OFF, {12'h0, {sg[d], 4'h0} + of[oI[k]]});
                    rd(CFS_ADRCTL_OFF, c | {23'h0, rf, 8'h0});
                end
            end
        end
        for (j = 0; j < 4; j++) begin
            wr(CFS_PSW_OFF, {21'h0, j[0], 10'h0});
            si = 16'($urandom);
            di = 16'($urandom);
            wr(CFS_SI_OFF, 32'(si));
            wr(CFS_DI_OFF, 32'(di));
            wr(CFS_STEP_OFF, {30'h0, j[1], 1'b0});
            st = j[1] ? 16'h0002 : 16'h0001;
            si = j[0] ? si - st : si + st;
            di = j[0] ? di - st : di + st;
            rd(CFS_SI_OFF, 32'(si));
            rd(CFS_DI_OFF, 32'(di));
        end
        for (j = 0; j < 16; j++) begin
            wr(CFS_PSW_OFF, {22'h0, j[3], 9'h0});
            @(posedge core_clk);
            swInt <= j[0];
            irqNmi <= j[1];
            irqMaskable <= j[2];
            c = j[0] ? 32'h1 : j[1] ? 32'h2 : (j[2] && j[3]) ? 32'h3 : 32'h0;
            if (c != 0)
                evQ.push_back({2'b01, c[1:0]});
            @(posedge core_clk);
            swInt <= 0;
            irqNmi <= 0;
            irqMaskable <= 0;
            @(posedge core_clk);
        end
        for (j = 0; j < 2; j++) begin
            wr(CFS_PSW_OFF, {23'h0, j[0], 8'h0});
            @(posedge core_clk);
            instrDone <= 1;
            if (j[0])
                evQ.push_back(4'b1000);
            @(posedge core_clk);
            instrDone <= 0;
            @(posedge core_clk);
        end
        // Let the last pulse reach the watcher before counting leftovers
        repeat (2) @(posedge core_clk);
        check(32'(evQ.size()), 32'h0);
        check(32'(expQ.size()), 32'h0);
        print_verdict();
    end
endmodule
